// ### ctu_evt_src.sv
// Purpose: event system model driving both event inputs
// Assumes: fire pulses one cycle, level is held by the bench
// Notes: lines change between edges like an unsynchronised source
module ctu_evt_src (
  // clock
  input wire logic sys_clk,
  // requests from the bench
  input wire logic [1:0] fire,
  input wire logic [1:0] level,
  // event lines
  output logic [1:0] event_in
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [1:0] sel = 2'h0;
  logic [1:0] cnt = 2'h0;

  always @(posedge sys_clk)
  begin
    if (fire != 2'h0)
    begin
      sel <= fire;
      cnt <= 2'h3;
    end
    else if (cnt != 2'h0)
      cnt <= cnt - 2'h1;
  end

  // fire pulse held three cycles from registers, level routed straight through unclocked
  assign #3 event_in = ((cnt != 2'h0) ? sel : 2'h0) | level;
endmodule : ctu_evt_src

// ### ctu_pkg.sv
// Purpose: constants and carrier types for the control timer unit
// Assumes: 16-bit counter, four compare channels, 8-bit byte address bus
// Notes: codes for commands, event actions and waveform modes live here
package ctu_pkg;

  localparam int CNT_W = 16;
  localparam int CH_NUM = 4;

  // register byte offsets
  localparam logic [7:0] OFS_CTRLA = 8'h00;
  localparam logic [7:0] OFS_CB_SET = 8'h04;
  localparam logic [7:0] OFS_CB_CLR = 8'h08;
  localparam logic [7:0] OFS_EVENT_CONTROL_REGISTER = 8'h0c;
  localparam logic [7:0] OFS_WAVE = 8'h10;
  localparam logic [7:0] OFS_DRV = 8'h14;
  localparam logic [7:0] OFS_FLAG = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_COUNT = 8'h20;
  localparam logic [7:0] OFS_PERIOD = 8'h24;
  localparam logic [7:0] OFS_CC_BASE = 8'h28;
  localparam logic [7:0] OFS_CCB_BASE = 8'h38;

  // control a fields
  localparam int BIT_ENABLE = 0;
  localparam int BIT_SWRST = 1;
  localparam int PRESC_LSB = 8;
  // control b fields
  localparam int BIT_DIR = 0;
  localparam int BIT_LUPD = 1;
  localparam int CMD_LSB = 5;
  // event control fields
  localparam int ACT0_LSB = 0;
  localparam int ACT1_LSB = 3;
  localparam int BIT_RETRIGGER_EVENT_OUT_ENABLE = 8;
  localparam int BIT_OVFEO = 9;
  localparam int MCEO_LSB = 12;
  // wave and driver fields
  localparam int WSEL_LSB = 0;
  localparam int CIRC_LSB = 8;
  localparam int NRE_LSB = 0;
  localparam int NRV_LSB = 8;
  // flag fields
  localparam int BIT_OVF = 0;
  localparam int BIT_TRG = 1;
  localparam int BIT_FAULT = 2;
  localparam int MC_LSB = 4;
  // status fields
  localparam int ST_RUN_BIT = 0;
  localparam int ST_DIR_BIT = 1;
  localparam int ST_SLOPE_BIT = 2;
  localparam int CCBV_LSB = 4;

  // software commands
  localparam logic [2:0] CMD_NONE = 3'h0;
  localparam logic [2:0] CMD_RETRIGGER = 3'h1;
  localparam logic [2:0] CMD_STOP = 3'h2;
  localparam logic [2:0] CMD_UPDATE = 3'h3;

  // event action codes
  localparam logic [2:0] ACT_OFF = 3'h0;
  localparam logic [2:0] ACT_RETRIGGER = 3'h1;
  localparam logic [2:0] ACT_DIR = 3'h2;
  localparam logic [2:0] ACT_START_STOP = 3'h3;
  localparam logic [2:0] ACT_INC_DEC = 3'h4;
  localparam logic [2:0] ACT_COUNT = 3'h5;
  localparam logic [2:0] ACT_FAULT = 3'h7;

  // waveform select codes
  localparam logic [2:0] WAVE_NORMAL_FREQ = 3'h0;
  localparam logic [2:0] WAVE_MATCH_FREQ = 3'h1;
  localparam logic [2:0] WAVE_SINGLE_SLOPE = 3'h2;
  localparam logic [2:0] WAVE_DUAL_TOP = 3'h3;
  localparam logic [2:0] WAVE_DUAL_BOTTOM = 3'h4;
  localparam logic [2:0] WAVE_DUAL_BOTH = 3'h5;
  localparam logic [2:0] WAVE_DUAL_CRITICAL = 3'h6;

  typedef enum logic [3:0] {
    ST_OFF = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_RUN = 4'b0100,
    ST_FAULT = 4'b1000
  } ctu_state_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ctu_bus_req_type;

  typedef struct packed {
    logic ovf;
    logic retrigger_flag;
    logic [CH_NUM-1:0] mc;
    logic [CH_NUM-1:0] dma;
  } ctu_evt_out_type;

endpackage : ctu_pkg

// ### ctu_timer.sv
// Purpose: counter commands, event actions, compare and waveform selection
// Assumes: event inputs arrive unsynchronised and pass two flip-flops
// Notes: one clock domain; software reset clears every register but the event synchroniser and read data
// Behaviour
// - software stop command halts counter
// - stop action on input one pauses counter
// - retrigger from command or either event input
// - running retrigger clears or reloads, flags, event
// - retrigger while stopped resumes from count
// - retrigger action: enable waits for first event
// - start event starts stopped counter, else ignored
// - start action: enable waits, no restarts
// - count action bypasses prescaler, follows direction
// - direction action level overrides direction bit
// - increment action on input zero counts up
// - decrement action on input one counts down
// - fault action stops counter, overrides outputs
// - all actions off: enable starts counter
// - channels compare on each counting tick while running
// - buffer copied only on update or command
// - match sets flag, event, dma request
// - seven waveform modes selectable
// - match frequency takes top from channel zero
// - dual slope updates at zero, others wrap
// - frequency toggles; overflow timing per mode
// - both-ends top update needs circular buffer
// - direction bit zero up, one down
// - wrap to zero up, reload top down
module ctu_timer (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register port
  input ctu_pkg::ctu_bus_req_type bus_req,
  output logic [31:0] bus_rdata,
  // event system
  input wire logic [1:0] event_in,
  output ctu_pkg::ctu_evt_out_type event_out,
  // waveform pins
  output logic [ctu_pkg::CH_NUM-1:0] wave_out
);
  import ctu_pkg::*;

  function automatic logic [CNT_W:0] ctu_step(input logic [CNT_W-1:0] cnt,
                                              input logic [CNT_W-1:0] top,
                                              input logic down);
    if (!down)
    begin
      ctu_step = (cnt >= top) ? {1'b1, {CNT_W{1'b0}}} : {1'b0, cnt + 1'b1};
    end
    else
    begin
      ctu_step = (cnt == '0) ? {1'b1, top} : {1'b0, cnt - 1'b1};
    end
  endfunction : ctu_step

  function automatic logic ctu_in_bank(input logic [7:0] addr, input logic [7:0] base);
    ctu_in_bank = (addr >= base) && (addr < base + 8'(4 * CH_NUM));
  endfunction : ctu_in_bank

  ctu_state_type state, next_state;
  logic enable, dir, lupd, retrigger_event_out_enable, ovfeo;
  logic [2:0] presc_sel, act0, act1, wsel;
  logic [CH_NUM-1:0] mceo, circ, nre, nrv, mc_flag, ccbv, wo;
  logic ovf_flag, trg_flag, fault_flag, slope_down;
  logic [CNT_W-1:0] count, period, top;
  logic [CNT_W-1:0] cc [CH_NUM];
  logic [CNT_W-1:0] ccb [CH_NUM];
  logic [9:0] presc_cnt, presc_lim;
  logic [1:0] ev_meta, ev_sync, ev_prev, ev_pulse;
  logic soft_rst, clr_all, wr_ctrla, wr_cbset, enable_rise, auto_start;
  logic [2:0] sw_cmd;
  logic retrig, start_ev, stop_ev, fault_ev, inc_ev, dec_ev;
  logic presc_tick, tick, running, dual, dir_eff;
  logic [CNT_W-1:0] next_count;
  logic next_slope, hit_top, hit_zero, wrapped, ovf_ev, upd_glob;
  logic [CNT_W:0] step_res;
  logic [CH_NUM-1:0] match, upd;
  logic [1:0] ch_sel;
  logic [7:0] ch_off;

  // channel index from the offset within either bank
  assign ch_off = bus_req.addr - OFS_CC_BASE;
  assign ch_sel = ch_off[3:2];
  assign wr_ctrla = bus_req.wr && (bus_req.addr == OFS_CTRLA);
  assign wr_cbset = bus_req.wr && (bus_req.addr == OFS_CB_SET);
  assign soft_rst = wr_ctrla && bus_req.wdata[BIT_SWRST];
  assign clr_all = rst || soft_rst;
  assign enable_rise = wr_ctrla && bus_req.wdata[BIT_ENABLE] && !enable;
  assign sw_cmd = wr_cbset ? bus_req.wdata[CMD_LSB +: 3] : CMD_NONE;

  // event input synchroniser and edge detect
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ev_meta <= 2'h0;
      ev_sync <= 2'h0;
      ev_prev <= 2'h0;
    end
    else
    begin
      ev_meta <= event_in;
      ev_sync <= ev_meta;
      ev_prev <= ev_sync;
    end
  end
  assign ev_pulse = ev_sync & ~ev_prev;

  // event and command decode
  assign retrig = (sw_cmd == CMD_RETRIGGER) || (ev_pulse[0] && act0 == ACT_RETRIGGER) ||
                  (ev_pulse[1] && act1 == ACT_RETRIGGER);
  assign start_ev = ev_pulse[0] && (act0 == ACT_START_STOP);
  assign stop_ev = (sw_cmd == CMD_STOP) ||
                   (ev_pulse[1] && act1 == ACT_START_STOP);
  assign fault_ev = (ev_pulse[0] && act0 == ACT_FAULT) ||
                    (ev_pulse[1] && act1 == ACT_FAULT);
  assign inc_ev = ev_pulse[0] && (act0 == ACT_INC_DEC);
  assign dec_ev = ev_pulse[1] && (act1 == ACT_INC_DEC);
  assign auto_start = !((act0 == ACT_RETRIGGER) || (act0 == ACT_START_STOP) ||
                        (act1 == ACT_RETRIGGER));
  assign dir_eff = (act1 == ACT_DIR) ? ev_sync[1] : dir;
  assign running = (state == ST_RUN);
  assign dual = (wsel >= WAVE_DUAL_TOP) && (wsel <= WAVE_DUAL_CRITICAL);
  assign top = (wsel == WAVE_MATCH_FREQ) ? cc[0] : period;

  // prescaler, bypassed when events are counted
  always_comb
  begin
    presc_lim = 10'h000;
    case (presc_sel)
      3'h0: presc_lim = 10'h000;
      3'h1: presc_lim = 10'h001;
      3'h2: presc_lim = 10'h003;
      3'h3: presc_lim = 10'h007;
      3'h4: presc_lim = 10'h00f;
      3'h5: presc_lim = 10'h03f;
      3'h6: presc_lim = 10'h0ff;
      default: presc_lim = 10'h3ff;
    endcase
  end
  assign presc_tick = running && (presc_cnt >= presc_lim);
  assign tick = (act0 == ACT_COUNT) ? (running && ev_pulse[0]) : presc_tick;

  always_ff @(posedge sys_clk)
  begin
    if (clr_all || !running || presc_tick)
      presc_cnt <= 10'h000;
    else
      presc_cnt <= presc_cnt + 10'h001;
  end

  // state machine
  always_comb
  begin
    next_state = state;
    case (state)
      ST_OFF: if (enable_rise) next_state = auto_start ? ST_RUN : ST_WAIT;
      ST_WAIT: if (retrig || start_ev) next_state = ST_RUN;
      ST_RUN: if (stop_ev) next_state = ST_WAIT;
      ST_FAULT: if (!fault_flag) next_state = ST_WAIT;
      default: next_state = ST_OFF;
    endcase
    if (fault_ev && state != ST_OFF)
      next_state = ST_FAULT;
    if (wr_ctrla && !bus_req.wdata[BIT_ENABLE])
      next_state = ST_OFF;
  end

  always_ff @(posedge sys_clk)
  begin
    if (clr_all)
      state <= ST_OFF;
    else
      state <= next_state;
  end

  // next counter value
  always_comb
  begin
    next_count = count;
    next_slope = slope_down;
    hit_top = 1'b0;
    hit_zero = 1'b0;
    wrapped = 1'b0;
    step_res = {1'b0, count};
    if (running && tick && dual)
    begin
      if (!slope_down)
      begin
        if (count >= top)
        begin
          hit_top = 1'b1;
          next_slope = 1'b1;
          next_count = count - 1'b1;
        end
        else
          next_count = count + 1'b1;
      end
      else if (count == '0)
      begin
        hit_zero = 1'b1;
        next_slope = 1'b0;
        next_count = count + 1'b1;
      end
      else
        next_count = count - 1'b1;
    end
    else if (running && (tick || inc_ev || dec_ev))
    begin
      step_res = ctu_step(count, top, inc_ev ? 1'b0 : (dec_ev ? 1'b1 : dir_eff));
      next_count = step_res[CNT_W-1:0];
      wrapped = step_res[CNT_W];
      hit_top = wrapped && !(dec_ev || (!inc_ev && dir_eff));
      hit_zero = wrapped && !hit_top;
    end
    if (running && retrig)
    begin
      next_count = dir_eff ? top : '0;
      next_slope = 1'b0;
    end
  end

  // overflow and update timing per mode
  always_comb
  begin
    ovf_ev = 1'b0;
    case (wsel)
      WAVE_DUAL_TOP: ovf_ev = hit_top;
      WAVE_DUAL_BOTTOM, WAVE_DUAL_CRITICAL: ovf_ev = hit_zero;
      WAVE_DUAL_BOTH: ovf_ev = hit_top || hit_zero;
      default: ovf_ev = wrapped;
    endcase
  end
  assign upd_glob = dual ? hit_zero : (wrapped || (running && retrig));

  genvar gi;
  generate
    for (gi = 0; gi < CH_NUM; gi++)
    begin : g_ch
      assign match[gi] = running && tick && (count == cc[gi]);
      assign upd[gi] = (upd_glob || (wsel == WAVE_DUAL_BOTH && hit_top && circ[gi])) &&
                       !lupd;
    end
  endgenerate

  // counter and slope
  always_ff @(posedge sys_clk)
  begin
    if (clr_all)
    begin
      count <= '0;
      slope_down <= 1'b0;
    end
    else if (bus_req.wr && bus_req.addr == OFS_COUNT)
      count <= bus_req.wdata[CNT_W-1:0];
    else
    begin
      count <= next_count;
      slope_down <= next_slope;
    end
  end

  // control registers
  always_ff @(posedge sys_clk)
  begin
    if (clr_all)
    begin
      enable <= 1'b0;
      presc_sel <= 3'h0;
      dir <= 1'b0;
      lupd <= 1'b0;
      act0 <= ACT_OFF;
      act1 <= ACT_OFF;
      retrigger_event_out_enable <= 1'b0;
      ovfeo <= 1'b0;
      mceo <= '0;
      wsel <= WAVE_NORMAL_FREQ;
      circ <= '0;
      nre <= '0;
      nrv <= '0;
      period <= '1;
    end
    else
    begin
      if (wr_ctrla)
      begin
        enable <= bus_req.wdata[BIT_ENABLE];
        if (!enable)
          presc_sel <= bus_req.wdata[PRESC_LSB +: 3];
      end
      if (act1 == ACT_DIR)
        dir <= ev_sync[1];
      else if (wr_cbset && bus_req.wdata[BIT_DIR])
        dir <= 1'b1;
      else if (bus_req.wr && bus_req.addr == OFS_CB_CLR && bus_req.wdata[BIT_DIR])
        dir <= 1'b0;
      if (wr_cbset && bus_req.wdata[BIT_LUPD])
        lupd <= 1'b1;
      else if (bus_req.wr && bus_req.addr == OFS_CB_CLR && bus_req.wdata[BIT_LUPD])
        lupd <= 1'b0;
      if (bus_req.wr && bus_req.addr == OFS_EVENT_CONTROL_REGISTER && !enable)
      begin
        act0 <= bus_req.wdata[ACT0_LSB +: 3];
        act1 <= bus_req.wdata[ACT1_LSB +: 3];
        retrigger_event_out_enable <= bus_req.wdata[BIT_RETRIGGER_EVENT_OUT_ENABLE];
        ovfeo <= bus_req.wdata[BIT_OVFEO];
        mceo <= bus_req.wdata[MCEO_LSB +: CH_NUM];
      end
      if (bus_req.wr && bus_req.addr == OFS_WAVE)
      begin
        wsel <= bus_req.wdata[WSEL_LSB +: 3];
        circ <= bus_req.wdata[CIRC_LSB +: CH_NUM];
      end
      if (bus_req.wr && bus_req.addr == OFS_DRV && !enable)
      begin
        nre <= bus_req.wdata[NRE_LSB +: CH_NUM];
        nrv <= bus_req.wdata[NRV_LSB +: CH_NUM];
      end
      if (bus_req.wr && bus_req.addr == OFS_PERIOD)
        period <= bus_req.wdata[CNT_W-1:0];
    end
  end

  // compare values and double buffers
  always_ff @(posedge sys_clk)
  begin
    if (clr_all)
    begin
      for (int i = 0; i < CH_NUM; i++)
      begin
        cc[i] <= '0;
        ccb[i] <= '0;
      end
      ccbv <= '0;
    end
    else
    begin
      for (int i = 0; i < CH_NUM; i++)
      begin
        if (bus_req.wr && ctu_in_bank(bus_req.addr, OFS_CCB_BASE) && ch_sel == 2'(i))
        begin
          ccb[i] <= bus_req.wdata[CNT_W-1:0];
          ccbv[i] <= 1'b1;
        end
        else if (ccbv[i] && (upd[i] || sw_cmd == CMD_UPDATE))
        begin
          cc[i] <= ccb[i];
          ccbv[i] <= 1'b0;
        end
        if (bus_req.wr && ctu_in_bank(bus_req.addr, OFS_CC_BASE) && ch_sel == 2'(i))
          cc[i] <= bus_req.wdata[CNT_W-1:0];
      end
    end
  end

  // sticky flags, set wins over clear
  always_ff @(posedge sys_clk)
  begin
    if (clr_all)
    begin
      ovf_flag <= 1'b0;
      trg_flag <= 1'b0;
      fault_flag <= 1'b0;
      mc_flag <= '0;
    end
    else
    begin
      if (ovf_ev)
        ovf_flag <= 1'b1;
      else if (bus_req.wr && bus_req.addr == OFS_FLAG && bus_req.wdata[BIT_OVF])
        ovf_flag <= 1'b0;
      if (running && retrig)
        trg_flag <= 1'b1;
      else if (bus_req.wr && bus_req.addr == OFS_FLAG && bus_req.wdata[BIT_TRG])
        trg_flag <= 1'b0;
      if (fault_ev && state != ST_OFF)
        fault_flag <= 1'b1;
      else if (bus_req.wr && bus_req.addr == OFS_FLAG && bus_req.wdata[BIT_FAULT])
        fault_flag <= 1'b0;
      for (int i = 0; i < CH_NUM; i++)
      begin
        if (match[i])
          mc_flag[i] <= 1'b1;
        else if (bus_req.wr && bus_req.addr == OFS_FLAG && bus_req.wdata[MC_LSB + i])
          mc_flag[i] <= 1'b0;
      end
    end
  end

  // event outputs and dma requests
  always_ff @(posedge sys_clk)
  begin
    if (clr_all)
      event_out <= '0;
    else
    begin
      event_out.ovf <= ovf_ev && ovfeo;
      event_out.retrigger_flag <= running && retrig && retrigger_event_out_enable;
      event_out.mc <= match & mceo;
      event_out.dma <= match;
    end
  end

  // waveform generation
  always_ff @(posedge sys_clk)
  begin
    if (clr_all)
      wo <= '0;
    else
    begin
      for (int i = 0; i < CH_NUM; i++)
      begin
        case (wsel)
          WAVE_NORMAL_FREQ, WAVE_MATCH_FREQ:
            if (match[i])
              wo[i] <= ~wo[i];
          WAVE_SINGLE_SLOPE:
            if (!dir_eff)
            begin
              if (hit_top)
                wo[i] <= 1'b1;
              else if (match[i])
                wo[i] <= 1'b0;
            end
            else
            begin
              if (hit_zero)
                wo[i] <= 1'b0;
              else if (match[i])
                wo[i] <= 1'b1;
            end
          default:
            if (match[i])
              wo[i] <= !slope_down;
        endcase
      end
    end
  end

  // fault override onto pins
  always_ff @(posedge sys_clk)
  begin
    if (clr_all)
      wave_out <= '0;
    else
      wave_out <= (fault_flag ? (nre & nrv) : '0) | (wo & ~(fault_flag ? nre : '0));
  end

  // register read, data one cycle after strobe
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      bus_rdata <= 32'h0000_0000;
    else if (bus_req.rd)
    begin
      bus_rdata <= 32'h0000_0000;
      case (bus_req.addr)
        OFS_CTRLA:
        begin
          bus_rdata[BIT_ENABLE] <= enable;
          bus_rdata[PRESC_LSB +: 3] <= presc_sel;
        end
        OFS_CB_SET, OFS_CB_CLR:
        begin
          bus_rdata[BIT_DIR] <= dir;
          bus_rdata[BIT_LUPD] <= lupd;
        end
        OFS_EVENT_CONTROL_REGISTER:
        begin
          bus_rdata[ACT0_LSB +: 3] <= act0;
          bus_rdata[ACT1_LSB +: 3] <= act1;
          bus_rdata[BIT_RETRIGGER_EVENT_OUT_ENABLE] <= retrigger_event_out_enable;
          bus_rdata[BIT_OVFEO] <= ovfeo;
          bus_rdata[MCEO_LSB +: CH_NUM] <= mceo;
        end
        OFS_WAVE:
        begin
          bus_rdata[WSEL_LSB +: 3] <= wsel;
          bus_rdata[CIRC_LSB +: CH_NUM] <= circ;
        end
        OFS_DRV:
        begin
          bus_rdata[NRE_LSB +: CH_NUM] <= nre;
          bus_rdata[NRV_LSB +: CH_NUM] <= nrv;
        end
        OFS_FLAG:
        begin
          bus_rdata[BIT_OVF] <= ovf_flag;
          bus_rdata[BIT_TRG] <= trg_flag;
          bus_rdata[BIT_FAULT] <= fault_flag;
          bus_rdata[MC_LSB +: CH_NUM] <= mc_flag;
        end
        OFS_STATUS:
        begin
          bus_rdata[ST_RUN_BIT] <= running;
          bus_rdata[ST_DIR_BIT] <= dir_eff;
          bus_rdata[ST_SLOPE_BIT] <= slope_down;
          bus_rdata[CCBV_LSB +: CH_NUM] <= ccbv;
        end
        OFS_COUNT: bus_rdata[CNT_W-1:0] <= count;
        OFS_PERIOD: bus_rdata[CNT_W-1:0] <= period;
        default:
        begin
          if (ctu_in_bank(bus_req.addr, OFS_CC_BASE))
            bus_rdata[CNT_W-1:0] <= cc[ch_sel];
          else if (ctu_in_bank(bus_req.addr, OFS_CCB_BASE))
            bus_rdata[CNT_W-1:0] <= ccb[ch_sel];
        end
      endcase
    end
    else
      bus_rdata <= 32'h0000_0000;
  end

endmodule : ctu_timer

// ### ctu_timer_props.sv
// Purpose: port-level assertions for the control timer unit
// Assumes: sees only the top ports, one clock domain
// Notes: bound from the foot of this file
module ctu_timer_props (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register port
  input ctu_pkg::ctu_bus_req_type bus_req,
  input wire logic [31:0] bus_rdata,
  // events and pins
  input wire logic [1:0] event_in,
  input ctu_pkg::ctu_evt_out_type event_out,
  input wire logic [ctu_pkg::CH_NUM-1:0] wave_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import ctu_pkg::*;

  logic [1:0] ev_q;
  logic [3:0] age;
  logic en_seen;
  logic cause;
  logic ctrla_wr;

  assign ctrla_wr = bus_req.wr && bus_req.addr == OFS_CTRLA;
  assign cause = (bus_req.wr && bus_req.addr == OFS_CB_SET
                  && bus_req.wdata[CMD_LSB +: 3] == CMD_RETRIGGER) || (|(event_in & ~ev_q));

  // cycles since the last possible retrigger cause
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ev_q <= 2'h0;
      age <= 4'hf;
    end
    else
    begin
      ev_q <= event_in;
      age <= cause ? 4'h0 : (age == 4'hf ? age : age + 4'h1);
    end
  end

  // set once the block has been enabled
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      en_seen <= 1'b0;
    else if (ctrla_wr && bus_req.wdata[BIT_SWRST])
      en_seen <= 1'b0;
    else if (ctrla_wr && bus_req.wdata[BIT_ENABLE])
      en_seen <= 1'b1;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_rdata_idle: assert property (!$past(bus_req.rd) |-> bus_rdata == 32'h0)
    else $error("read data outside read slot");
  a_unmapped_zero: assert property (bus_req.rd && bus_req.addr >= 8'h48 |=> bus_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_outs_reset: assert property (disable iff (1'b0)
    rst |=> event_out == '0 && wave_out == '0)
    else $error("outputs not cleared by reset");
  a_swrst_quiet: assert property (ctrla_wr && bus_req.wdata[BIT_SWRST]
    |-> ##3 (event_out == '0 && wave_out == '0))
    else $error("software reset left outputs active");
  a_mc_dma: assert property (|event_out.mc |-> (event_out.mc & ~event_out.dma) == '0)
    else $error("match event without dma request");
  a_trg_cause: assert property (event_out.retrigger_flag |-> age <= 4'h6)
    else $error("retrigger event without cause");
  a_evt_needs_en: assert property ((event_out.ovf || event_out.retrigger_flag || |event_out.dma)
    |-> en_seen)
    else $error("event while never enabled");
  a_quiet_release: assert property ($fell(rst) |-> event_out == '0 ##1 event_out == '0)
    else $error("event right after reset");
endmodule : ctu_timer_props

bind ctu_timer ctu_timer_props u_props (.sys_clk(sys_clk), .rst(rst), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .event_in(event_in), .event_out(event_out), .wave_out(wave_out));

// ### ctu_timer_test.sv
// Purpose: self-checking bench for the control timer unit
// Assumes: event model on both inputs, prescaler /1 mostly
// Notes: counts read back after a stop command or stop event, or while ticks come only from events or the /1024 prescaler
module ctu_timer_test
  import ctu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [31:0] EVB = 32'h2300;
  localparam logic [31:0] RTG = 32'h20;
  localparam logic [31:0] STP = 32'h40;
  localparam logic [31:0] UPD = 32'h60;

  logic sys_clk;
  logic rst;
  ctu_bus_req_type req;
  logic [31:0] bus_rdata;
  logic [1:0] event_in;
  logic [1:0] fire;
  logic [1:0] level;
  ctu_evt_out_type event_out;
  logic [3:0] wave_out;
  logic [3:0] saw_mc;
  logic [3:0] saw_dma;
  logic saw_trg;
  logic saw_ovf;
  int n_errors;
  int compares;

  ctu_timer u_dut (.sys_clk(sys_clk), .rst(rst), .bus_req(req), .bus_rdata(bus_rdata),
    .event_in(event_in), .event_out(event_out), .wave_out(wave_out));
  ctu_evt_src u_src (.sys_clk(sys_clk), .fire(fire), .level(level), .event_in(event_in));

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // sticky record of event pulses
  always @(posedge sys_clk)
  begin
    if (rst)
      {saw_mc, saw_dma, saw_trg, saw_ovf} <= '0;
    else
    begin
      saw_mc <= saw_mc | event_out.mc;
      saw_dma <= saw_dma | event_out.dma;
      saw_trg <= saw_trg | event_out.retrigger_flag;
      saw_ovf <= saw_ovf | event_out.ovf;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge sys_clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1 chk(bus_rdata & m, e);
  endtask : rd

  task automatic ev(input int i);
    @(posedge sys_clk);
    fire <= 2'h1 << i;
    @(posedge sys_clk);
    fire <= 2'h0;
    repeat (6) @(posedge sys_clk);
  endtask : ev

  task automatic cfg(input logic [31:0] v);
    wr(OFS_CTRLA, 32'h0);
    wr(OFS_EVENT_CONTROL_REGISTER, v);
    wr(OFS_CTRLA, 32'h1);
  endtask : cfg

  task automatic summarize;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    summarize;
  end

  initial
  begin
    rst = 1'b1;
    req = '0;
    fire = 2'h0;
    level = 2'h0;
    n_errors = 0;
    compares = 0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    rd(OFS_PERIOD, 32'hffffffff, 32'hffff);
    rd(OFS_COUNT, 32'hffffffff, 32'h0);
    rd(8'h48, 32'hffffffff, 32'h0);
    cfg(EVB);
    rd(OFS_STATUS, 32'h1, 32'h1);
    wr(OFS_CB_SET, STP);
    wr(OFS_COUNT, 32'h100);
    repeat (5) @(posedge sys_clk);
    rd(OFS_COUNT, 32'hffff, 32'h100);
    rd(OFS_STATUS, 32'h1, 32'h0);
    wr(OFS_CB_SET, RTG);
    wr(OFS_CB_SET, STP);
    rd(OFS_COUNT, 32'hff00, 32'h100);
    wr(OFS_FLAG, 32'hff);
    wr(OFS_CB_SET, RTG);
    wr(OFS_COUNT, 32'h1000);
    wr(OFS_CB_SET, RTG);
    wr(OFS_CB_SET, STP);
    rd(OFS_COUNT, 32'hfff0, 32'h0);
    rd(OFS_FLAG, 32'h2, 32'h2);
    chk({31'h0, saw_trg}, 32'h1);
    wr(OFS_CB_SET, 32'h1);
    wr(OFS_CB_SET, RTG);
    wr(OFS_CB_SET, RTG);
    wr(OFS_CB_SET, STP);
    rd(OFS_COUNT, 32'hfff0, 32'hfff0);
    wr(OFS_CB_CLR, 32'h1);
    wr(OFS_CB_SET, 32'h2);
    wr(OFS_CC_BASE, 32'h11);
    wr(OFS_CCB_BASE, 32'h55);
    rd(OFS_CC_BASE, 32'hffff, 32'h11);
    wr(OFS_CB_SET, UPD);
    rd(OFS_CC_BASE, 32'hffff, 32'h55);
    wr(OFS_CB_CLR, 32'h2);
    wr(OFS_COUNT, 32'h30);
    wr(OFS_CC_BASE + 8'h4, 32'h40);
    wr(OFS_FLAG, 32'hff);
    wr(OFS_CB_SET, RTG);
    repeat (40) @(posedge sys_clk);
    wr(OFS_CB_SET, STP);
    rd(OFS_FLAG, 32'h20, 32'h20);
    chk({30'h0, saw_mc[1], saw_dma[1]}, 32'h3);
    wr(OFS_WAVE, 32'h1);
    wr(OFS_COUNT, 32'h0);
    wr(OFS_FLAG, 32'hff);
    wr(OFS_CB_SET, RTG);
    repeat (300) @(posedge sys_clk);
    wr(OFS_CB_SET, STP);
    rd(OFS_COUNT, 32'hff80, 32'h0);
    rd(OFS_FLAG, 32'h1, 32'h1);
    chk({31'h0, saw_ovf}, 32'h1);
    wr(OFS_PERIOD, 32'h8);
    wr(OFS_WAVE, 32'h4);
    wr(OFS_COUNT, 32'h0);
    wr(OFS_CCB_BASE + 8'h8, 32'h3);
    wr(OFS_FLAG, 32'hff);
    wr(OFS_CB_SET, RTG);
    repeat (30) @(posedge sys_clk);
    wr(OFS_CB_SET, STP);
    rd(OFS_CC_BASE + 8'h8, 32'hffff, 32'h3);
    rd(OFS_FLAG, 32'h1, 32'h1);
    wr(OFS_PERIOD, 32'hffff);
    for (int m = 0; m < 7; m++)
    begin
      wr(OFS_WAVE, m);
      rd(OFS_WAVE, 32'h7, m);
    end
    wr(OFS_WAVE, 32'h0);
    cfg(EVB | 32'h1b);
    rd(OFS_STATUS, 32'h1, 32'h0);
    ev(0);
    rd(OFS_STATUS, 32'h1, 32'h1);
    wr(OFS_COUNT, 32'h1000);
    ev(0);
    ev(1);
    rd(OFS_STATUS, 32'h1, 32'h0);
    rd(OFS_COUNT, 32'hf000, 32'h1000);
    cfg(EVB | 32'h1);
    rd(OFS_STATUS, 32'h1, 32'h0);
    ev(0);
    rd(OFS_STATUS, 32'h1, 32'h1);
    wr(OFS_COUNT, 32'h1000);
    ev(0);
    wr(OFS_CB_SET, STP);
    rd(OFS_COUNT, 32'hffe0, 32'h0);
    cfg(EVB | 32'h8);
    ev(1);
    rd(OFS_STATUS, 32'h1, 32'h1);
    cfg(EVB | 32'h25);
    wr(OFS_COUNT, 32'h10);
    ev(0);
    ev(0);
    rd(OFS_COUNT, 32'hffff, 32'h12);
    ev(1);
    rd(OFS_COUNT, 32'hffff, 32'h11);
    wr(OFS_CB_SET, 32'h1);
    ev(0);
    rd(OFS_COUNT, 32'hffff, 32'h10);
    wr(OFS_CTRLA, 32'h0);
    wr(OFS_EVENT_CONTROL_REGISTER, EVB | 32'h4);
    wr(OFS_CTRLA, 32'h701);
    wr(OFS_COUNT, 32'h1000);
    ev(0);
    rd(OFS_COUNT, 32'hffff, 32'h1001);
    wr(OFS_CB_CLR, 32'h1);
    cfg(EVB | 32'h10);
    level <= 2'h2;
    repeat (5) @(posedge sys_clk);
    rd(OFS_STATUS, 32'h2, 32'h2);
    level <= 2'h0;
    repeat (5) @(posedge sys_clk);
    rd(OFS_STATUS, 32'h2, 32'h0);
    wr(OFS_CTRLA, 32'h0);
    wr(OFS_DRV, 32'h50f);
    cfg(EVB | 32'h7);
    ev(0);
    chk({28'h0, wave_out}, 32'h5);
    rd(OFS_STATUS, 32'h1, 32'h0);
    rd(OFS_FLAG, 32'h4, 32'h4);
    wr(OFS_CTRLA, 32'h2);
    repeat (4) @(posedge sys_clk);
    chk({28'h0, wave_out}, 32'h0);
    rd(OFS_EVENT_CONTROL_REGISTER, 32'hffffffff, 32'h0);
    summarize;
  end
endmodule : ctu_timer_test
